// ==== hw/hif_pkg.sv ====
// Constants and types of the host interface front end
package hif_pkg;
  localparam int unsigned CLK_HZ         = 125_000_000;
  localparam int unsigned TWI_STD_HZ     = 100_000;
  localparam int unsigned TWI_FAST_HZ    = 400_000;
  localparam int unsigned SPI_MAX_HZ     = 4_000_000;
  localparam int unsigned LIN_BAUD       = 20_000;
  localparam int unsigned STARTUP_MS     = 110;
  localparam int unsigned STARTUP_CYCLES = STARTUP_MS * (CLK_HZ / 1000);
  localparam int unsigned BAUD_DIV       = CLK_HZ / LIN_BAUD;
  localparam int unsigned TIMER_W        = 24;
  localparam logic [6:0]  TWI_ADDR_LOW   = 7'h66;
  localparam logic [6:0]  TWI_ADDR_HIGH  = 7'h67;
  localparam logic [1:0]  LIN_STRAP_DEF  = 2'h3;
  localparam int unsigned MEM_AW         = 7;
  localparam int unsigned MEM_DW         = 8;
  localparam logic [6:0]  REPORT_ADDR    = 7'h00;
  localparam logic [6:0]  LOADER_ADDR    = 7'h7f;
  localparam logic [3:0]  BYTE_BITS      = 4'h8;
  localparam logic [2:0]  SPI_LAST_BIT   = 3'h7;
  localparam logic [1:0]  STRAP_SETTLE   = 2'h3;
  typedef enum logic [1:0] {MODE_TWI, MODE_SPI, MODE_LIN} hif_mode_t;
  typedef enum logic [1:0] {ST_SETTLE, ST_BOOT, ST_RUN} hif_boot_t;
  typedef enum logic [2:0] {TW_IDLE, TW_ADDR, TW_ACK, TW_WR, TW_RD, TW_RACK} hif_twi_t;
  typedef enum logic [1:0] {UR_IDLE, UR_START, UR_DATA, UR_STOP} hif_uart_t;
endpackage : hif_pkg

// ==== hw/hif_regmem.sv ====
// Register and report memory behind the host protocol
`timescale 1ns/1ps
module hif_regmem #(
  parameter int unsigned AW = hif_pkg::MEM_AW,
  parameter int unsigned DW = hif_pkg::MEM_DW
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : hif_regmem

// ==== hw/hif_select.sv ====
// Host interface front end: strap select, two-wire, serial peripheral and UART slaves
`timescale 1ns/1ps
module hif_select #(
  parameter int unsigned STARTUP_CYCLES = hif_pkg::STARTUP_CYCLES,
  parameter int unsigned BAUD_DIV       = hif_pkg::BAUD_DIV,
  parameter logic [1:0]  LIN_STRAP      = hif_pkg::LIN_STRAP_DEF,
  parameter bit          LIN_EN_ON_IRQ  = 1'b1
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       spi_link_clk,
  input  wire logic       slave_serial_data_in,
  output logic            slave_serial_data_out,
  output logic            slave_serial_data_oe,
  input  wire logic       slave_serial_clock_in,
  output logic            slave_serial_clock_out,
  output logic            slave_serial_clock_oe,
  input  wire logic       bus_address_strap,
  input  wire logic       interface_select_strap_n_in,
  output logic            interface_select_strap_n_out,
  output logic            interface_select_strap_n_oe,
  output logic            host_interrupt_n,
  input  wire logic       report_event,
  output logic [1:0]      link_mode,
  output logic            operational
);
  typedef logic [hif_pkg::TIMER_W-1:0] tim_t;

  function automatic tim_t tim(input int unsigned v);
    tim = tim_t'(v);
  endfunction : tim

  // Pin synchronisers
  logic [1:0] sda_s, scl_s, adr_s, sel_s;
  logic       sda_q, scl_q;
  always_ff @(posedge clk) begin
    sda_s <= {sda_s[0], slave_serial_data_in};
    scl_s <= {scl_s[0], slave_serial_clock_in};
    adr_s <= {adr_s[0], bus_address_strap};
    sel_s <= {sel_s[0], interface_select_strap_n_in};
    sda_q <= sda_s[1];
    scl_q <= scl_s[1];
  end
  wire sda = sda_s[1];
  wire scl = scl_s[1];

  // Strap latch and startup timer
  hif_pkg::hif_boot_t  boot, next_boot;
  hif_pkg::hif_mode_t  mode, next_mode;
  logic [6:0]          own_addr, next_own_addr;
  tim_t                tmr, next_tmr;
  logic                hello, next_hello;
  always_comb begin
    next_boot     = boot;
    next_mode     = mode;
    next_own_addr = own_addr;
    next_tmr      = tmr;
    next_hello    = 1'b0;
    unique case (boot)
      hif_pkg::ST_SETTLE: begin
        next_tmr = tmr + 1'b1;
        if (tmr == tim(hif_pkg::STRAP_SETTLE)) begin
          next_boot = hif_pkg::ST_BOOT;
          next_tmr  = '0;
          if ({sel_s[1], adr_s[1]} == LIN_STRAP)
            next_mode = hif_pkg::MODE_LIN;
          else if (sel_s[1])
            next_mode = hif_pkg::MODE_SPI;
          else
            next_mode = hif_pkg::MODE_TWI;
          next_own_addr = adr_s[1] ? hif_pkg::TWI_ADDR_HIGH : hif_pkg::TWI_ADDR_LOW;
        end
      end
      hif_pkg::ST_BOOT: begin
        next_tmr = tmr + 1'b1;
        if (tmr == tim(STARTUP_CYCLES - 1)) begin
          next_boot  = hif_pkg::ST_RUN;
          next_hello = 1'b1;
        end
      end
      hif_pkg::ST_RUN: ;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      boot     <= hif_pkg::ST_SETTLE;
      mode     <= hif_pkg::MODE_TWI;
      own_addr <= hif_pkg::TWI_ADDR_LOW;
      tmr      <= '0;
      hello    <= 1'b0;
    end else begin
      boot     <= next_boot;
      mode     <= next_mode;
      own_addr <= next_own_addr;
      tmr      <= next_tmr;
      hello    <= next_hello;
    end
  end
  wire run = (boot == hif_pkg::ST_RUN);

  // Protocol engine shared by every interface
  logic       rx_valid;
  logic [7:0] rx_byte;
  logic       tx_taken;
  logic       frame_start;
  logic [7:0] tx_byte;
  logic [6:0] addr, next_addr;
  logic       cmd_phase, next_cmd_phase;
  logic       rd, next_rd;
  logic       pend, next_pend;
  logic       mem_we;
  always_comb begin
    next_addr      = addr;
    next_cmd_phase = cmd_phase | frame_start;
    next_rd        = rd;
    next_pend      = pend;
    mem_we         = 1'b0;
    if (rx_valid && run) begin
      if (cmd_phase || frame_start) begin
        next_addr      = rx_byte[6:0];
        next_rd        = rx_byte[7];
        next_cmd_phase = 1'b0;
      end else if (!rd) begin
        mem_we    = 1'b1;
        next_addr = addr + 1'b1;
      end
    end
    if (tx_taken) begin
      next_addr = addr + 1'b1;
      if (addr == hif_pkg::REPORT_ADDR)
        next_pend = 1'b0;
      if (mode == hif_pkg::MODE_LIN)
        next_cmd_phase = 1'b1;
    end
    if (hello || (report_event && run))
      next_pend = 1'b1;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr      <= '0;
      cmd_phase <= 1'b1;
      rd        <= 1'b0;
      pend      <= 1'b0;
    end else begin
      addr      <= next_addr;
      cmd_phase <= next_cmd_phase;
      rd        <= next_rd;
      pend      <= next_pend;
    end
  end

  // Registers and report buffer; loader window shares the map
  hif_regmem #(.AW(hif_pkg::MEM_AW), .DW(hif_pkg::MEM_DW)) u_mem (
    .clk   (clk),
    .we    (mem_we),
    .waddr (addr),
    .wdata (rx_byte),
    .raddr (addr),
    .rdata (tx_byte)
  );

  // Two-wire slave
  hif_pkg::hif_twi_t tw, next_tw;
  logic [7:0] tw_sh, next_tw_sh;
  logic [3:0] tw_cnt, next_tw_cnt;
  logic       tw_rw, next_tw_rw, tw_oe, next_tw_oe;
  logic       tw_rx, tw_tx, tw_start;
  wire        tw_on   = run && (mode == hif_pkg::MODE_TWI);
  wire        scl_r   = scl & ~scl_q;
  wire        scl_f   = ~scl & scl_q;
  wire        t_start = scl & scl_q & sda_q & ~sda;
  wire        t_stop  = scl & scl_q & ~sda_q & sda;
  always_comb begin
    next_tw     = tw;
    next_tw_sh  = tw_sh;
    next_tw_cnt = tw_cnt;
    next_tw_rw  = tw_rw;
    next_tw_oe  = tw_oe;
    tw_rx       = 1'b0;
    tw_tx       = 1'b0;
    tw_start    = 1'b0;
    if (!tw_on || t_stop) begin
      next_tw    = hif_pkg::TW_IDLE;
      next_tw_oe = 1'b0;
    end else if (t_start) begin
      next_tw     = hif_pkg::TW_ADDR;
      next_tw_cnt = '0;
      next_tw_oe  = 1'b0;
    end else begin
      unique case (tw)
        hif_pkg::TW_IDLE: ;
        hif_pkg::TW_ADDR, hif_pkg::TW_WR: begin
          if (scl_r) begin
            next_tw_sh  = {tw_sh[6:0], sda};
            next_tw_cnt = tw_cnt + 1'b1;
          end else if (scl_f && tw_cnt == hif_pkg::BYTE_BITS) begin
            if (tw == hif_pkg::TW_WR) begin
              tw_rx      = 1'b1;
              next_tw    = hif_pkg::TW_ACK;
              next_tw_oe = 1'b1;
            end else if (tw_sh[7:1] == own_addr) begin
              next_tw_rw = tw_sh[0];
              tw_start   = ~tw_sh[0];
              next_tw    = hif_pkg::TW_ACK;
              next_tw_oe = 1'b1;
            end else begin
              next_tw = hif_pkg::TW_IDLE;
            end
          end
        end
        hif_pkg::TW_ACK: begin
          if (scl_f) begin
            next_tw_cnt = '0;
            next_tw_oe  = 1'b0;
            next_tw     = hif_pkg::TW_WR;
            if (tw_rw) begin
              tw_tx       = 1'b1;
              next_tw_sh  = tx_byte;
              next_tw_oe  = ~tx_byte[7];
              next_tw_cnt = 4'h1;
              next_tw     = hif_pkg::TW_RD;
            end
          end
        end
        hif_pkg::TW_RD: begin
          if (scl_f) begin
            next_tw_cnt = tw_cnt + 1'b1;
            next_tw_sh  = {tw_sh[6:0], 1'b0};
            next_tw_oe  = ~tw_sh[6];
            if (tw_cnt == hif_pkg::BYTE_BITS) begin
              next_tw_oe = 1'b0;
              next_tw    = hif_pkg::TW_RACK;
            end
          end
        end
        hif_pkg::TW_RACK: begin
          if (scl_r)
            next_tw = sda ? hif_pkg::TW_IDLE : hif_pkg::TW_ACK;
        end
        default: next_tw = hif_pkg::TW_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tw     <= hif_pkg::TW_IDLE;
      tw_sh  <= '0;
      tw_cnt <= '0;
      tw_rw  <= 1'b0;
      tw_oe  <= 1'b0;
    end else begin
      tw     <= next_tw;
      tw_sh  <= next_tw_sh;
      tw_cnt <= next_tw_cnt;
      tw_rw  <= next_tw_rw;
      tw_oe  <= next_tw_oe;
    end
  end

  // Serial peripheral link side, on the host clock
  logic [1:0] lrst_s;
  logic [2:0] l_cnt, next_l_cnt;
  logic [7:0] l_sh, next_l_sh, l_byte, next_l_byte, l_tx, next_l_tx;
  logic       l_tgl, next_l_tgl, l_miso, next_l_miso;
  always_ff @(posedge spi_link_clk) begin
    lrst_s <= {lrst_s[0], rst_n};
  end
  always_comb begin
    next_l_cnt  = l_cnt + 1'b1;
    next_l_sh   = {l_sh[6:0], bus_address_strap};
    next_l_byte = l_byte;
    next_l_tgl  = l_tgl;
    if (!lrst_s[1] || slave_serial_clock_in) begin
      next_l_cnt = '0;
    end else if (l_cnt == hif_pkg::SPI_LAST_BIT) begin
      next_l_byte = next_l_sh;
      next_l_tgl  = ~l_tgl;
    end
    // Toggle starts from a known level once the link has seen reset
    if (!lrst_s[1])
      next_l_tgl = 1'b0;
  end
  always_ff @(posedge spi_link_clk) begin
    l_cnt  <= next_l_cnt;
    l_sh   <= next_l_sh;
    l_byte <= next_l_byte;
    l_tgl  <= next_l_tgl;
  end
  // Read data is held by the core for a whole byte, so it is stable here
  always_comb begin
    next_l_tx   = {l_tx[6:0], 1'b0};
    next_l_miso = l_tx[7];
    if (l_cnt == '0) begin
      next_l_tx   = {tx_byte[6:0], 1'b0};
      next_l_miso = tx_byte[7];
    end
  end
  always_ff @(negedge spi_link_clk) begin
    l_tx   <= next_l_tx;
    l_miso <= next_l_miso;
  end

  // Serial peripheral core side: byte event by toggle, select by level
  logic [2:0] tg_s;
  logic [7:0] sp_byte;
  always_ff @(posedge clk) begin
    tg_s    <= {tg_s[1:0], l_tgl};
    sp_byte <= l_byte;
  end
  wire sp_on  = run && (mode == hif_pkg::MODE_SPI);
  wire sp_ev  = sp_on && (tg_s[2] ^ tg_s[1]);
  wire sp_sel = sp_on && !scl;

  // UART link slave
  hif_pkg::hif_uart_t ur, next_ur, ut, next_ut;
  tim_t       ur_div, next_ur_div, ut_div, next_ut_div;
  logic [3:0] ur_cnt, next_ur_cnt, ut_cnt, next_ut_cnt;
  logic [7:0] ur_sh, next_ur_sh;
  logic [8:0] ut_sh, next_ut_sh;
  logic       ur_ev, ut_go;
  wire        lin_on = run && (mode == hif_pkg::MODE_LIN);
  always_comb begin
    next_ur     = ur;
    next_ur_div = ur_div - 1'b1;
    next_ur_cnt = ur_cnt;
    next_ur_sh  = ur_sh;
    ur_ev       = 1'b0;
    unique case (ur)
      hif_pkg::UR_IDLE: begin
        next_ur_div = tim(BAUD_DIV / 2);
        if (lin_on && !sda)
          next_ur = hif_pkg::UR_START;
      end
      hif_pkg::UR_START: if (ur_div == '0) begin
        next_ur     = sda ? hif_pkg::UR_IDLE : hif_pkg::UR_DATA;
        next_ur_div = tim(BAUD_DIV - 1);
        next_ur_cnt = '0;
      end
      hif_pkg::UR_DATA: if (ur_div == '0) begin
        next_ur_sh  = {sda, ur_sh[7:1]};
        next_ur_cnt = ur_cnt + 1'b1;
        next_ur_div = tim(BAUD_DIV - 1);
        if (ur_cnt == hif_pkg::BYTE_BITS - 1'b1)
          next_ur = hif_pkg::UR_STOP;
      end
      hif_pkg::UR_STOP: if (ur_div == '0) begin
        ur_ev   = sda;
        next_ur = hif_pkg::UR_IDLE;
      end
    endcase
  end
  always_comb begin
    next_ut     = ut;
    next_ut_div = ut_div - 1'b1;
    next_ut_cnt = ut_cnt;
    next_ut_sh  = ut_sh;
    ut_go       = 1'b0;
    unique case (ut)
      hif_pkg::UR_IDLE: if (lin_on && rd && !cmd_phase && ur == hif_pkg::UR_IDLE) begin
        ut_go       = 1'b1;
        next_ut_sh  = {tx_byte, 1'b0};
        next_ut_div = tim(BAUD_DIV - 1);
        next_ut_cnt = '0;
        next_ut     = hif_pkg::UR_DATA;
      end
      hif_pkg::UR_DATA: if (ut_div == '0) begin
        next_ut_sh  = {1'b1, ut_sh[8:1]};
        next_ut_div = tim(BAUD_DIV - 1);
        next_ut_cnt = ut_cnt + 1'b1;
        if (ut_cnt == hif_pkg::BYTE_BITS)
          next_ut = hif_pkg::UR_STOP;
      end
      hif_pkg::UR_STOP: if (ut_div == '0)
        next_ut = hif_pkg::UR_IDLE;
      hif_pkg::UR_START: next_ut = hif_pkg::UR_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ur     <= hif_pkg::UR_IDLE;
      ut     <= hif_pkg::UR_IDLE;
      ur_div <= '0;
      ut_div <= '0;
      ur_cnt <= '0;
      ut_cnt <= '0;
      ur_sh  <= '0;
      ut_sh  <= '1;
    end else begin
      ur     <= next_ur;
      ut     <= next_ut;
      ur_div <= next_ur_div;
      ut_div <= next_ut_div;
      ur_cnt <= next_ur_cnt;
      ut_cnt <= next_ut_cnt;
      ur_sh  <= next_ur_sh;
      ut_sh  <= next_ut_sh;
    end
  end

  // Interface multiplexing into the engine
  always_comb begin
    rx_valid    = tw_rx | sp_ev | ur_ev;
    rx_byte     = tw_rx ? tw_sh : (sp_ev ? sp_byte : ur_sh);
    tx_taken    = tw_tx | (sp_ev & rd & ~cmd_phase) | ut_go;
    frame_start = tw_start;
  end

  // Pin drivers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      slave_serial_data_out        <= 1'b0;
      slave_serial_data_oe         <= 1'b0;
      slave_serial_clock_out       <= 1'b1;
      slave_serial_clock_oe        <= 1'b0;
      interface_select_strap_n_out <= 1'b0;
      interface_select_strap_n_oe  <= 1'b0;
      host_interrupt_n             <= 1'b1;
      link_mode                    <= '0;
      operational                  <= 1'b0;
    end else begin
      slave_serial_data_out        <= 1'b0;
      slave_serial_data_oe         <= tw_oe;
      slave_serial_clock_out       <= ut_sh[0];
      slave_serial_clock_oe        <= lin_on;
      interface_select_strap_n_out <= l_miso;
      interface_select_strap_n_oe  <= sp_sel;
      if (lin_on && LIN_EN_ON_IRQ)
        host_interrupt_n <= 1'b1;
      else
        host_interrupt_n <= ~pend;
      link_mode   <= mode;
      operational <= run;
    end
  end
endmodule : hif_select

// ==== dv/hif_select_chk.sv ====
// Concurrent checks on the ports of the host interface front end
`timescale 1ns/1ps
module hif_select_chk #(
  parameter int unsigned STARTUP_CYCLES = hif_pkg::STARTUP_CYCLES
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       slave_serial_data_out,
  input wire logic       slave_serial_clock_in,
  input wire logic       slave_serial_clock_oe,
  input wire logic       interface_select_strap_n_oe,
  input wire logic       host_interrupt_n,
  input wire logic       report_event,
  input wire logic [1:0] link_mode,
  input wire logic       operational
);
  default clocking cb @(posedge clk);
  endclocking

  int unsigned boot_cnt;
  int unsigned next_boot_cnt;

  // Cycles spent since reset release without being operational
  always_comb begin
    next_boot_cnt = boot_cnt;
    if (!rst_n) next_boot_cnt = 0;
    else if (!operational) next_boot_cnt = boot_cnt + 1;
  end

  always_ff @(posedge clk) begin
    boot_cnt <= next_boot_cnt;
  end

  sequence s_select_high;
    slave_serial_clock_in [*5];
  endsequence

  sequence s_select_low;
    !slave_serial_clock_in [*5];
  endsequence

  sequence s_booted;
    $rose(operational) ##0 link_mode != 2'h2;
  endsequence

  chk_reset_quiet: assert property (!rst_n |=> host_interrupt_n && !operational
      && link_mode == 2'h0 && !slave_serial_clock_oe && !interface_select_strap_n_oe)
    else $error("outputs not quiet after reset");
  chk_mode_latched: assert property (disable iff (!rst_n) $past(operational) |-> $stable(link_mode))
    else $error("link mode changed after startup");
  chk_mode_legal: assert property (disable iff (!rst_n) link_mode != 2'h3)
    else $error("illegal link mode");
  chk_startup_time: assert property (disable iff (!rst_n) $rose(operational)
      |-> boot_cnt >= STARTUP_CYCLES && boot_cnt <= STARTUP_CYCLES + 8)
    else $error("startup time off");
  chk_hello_irq: assert property (disable iff (!rst_n) s_booted |-> ##[1:2] !host_interrupt_n)
    else $error("no hello interrupt after startup");
  chk_event_irq: assert property (disable iff (!rst_n)
      operational && link_mode != 2'h2 && report_event |-> ##[1:3] !host_interrupt_n)
    else $error("report event did not raise interrupt");
  chk_lin_enable: assert property (disable iff (!rst_n) link_mode == 2'h2 && operational
      |-> host_interrupt_n)
    else $error("transceiver enable not held");
  chk_tx_owner: assert property (disable iff (!rst_n) slave_serial_clock_oe
      |-> link_mode == 2'h2 && operational)
    else $error("clock pin driven outside uart mode");
  chk_miso_mode: assert property (disable iff (!rst_n) interface_select_strap_n_oe
      |-> link_mode == 2'h1)
    else $error("select strap driven outside spi mode");
  chk_miso_drive: assert property (disable iff (!rst_n)
      link_mode == 2'h1 && operational ##0 s_select_low |-> interface_select_strap_n_oe)
    else $error("miso not driven while selected");
  chk_miso_release: assert property (disable iff (!rst_n)
      link_mode == 2'h1 ##0 s_select_high |-> !interface_select_strap_n_oe)
    else $error("miso driven while deselected");
  chk_open_drain: assert property (disable iff (!rst_n) slave_serial_data_out == 1'b0)
    else $error("data pin driven high");
endmodule : hif_select_chk

bind hif_select hif_select_chk #(.STARTUP_CYCLES(STARTUP_CYCLES)) i_chk (
  .clk(clk), .rst_n(rst_n), .slave_serial_data_out(slave_serial_data_out),
  .slave_serial_clock_in(slave_serial_clock_in), .slave_serial_clock_oe(slave_serial_clock_oe),
  .interface_select_strap_n_oe(interface_select_strap_n_oe),
  .host_interrupt_n(host_interrupt_n), .report_event(report_event),
  .link_mode(link_mode), .operational(operational));

// ==== dv/hif_host_model.sv ====
// Host master model for the two-wire and serial peripheral links
`timescale 1ns/1ps
module hif_host_model (
  input  wire logic clk,
  input  wire logic pin_a,
  input  wire logic miso,
  input  wire logic addr_strap,
  output logic      pin_a_drv,
  output logic      pin_b_drv,
  output logic      mosi
);
  localparam int H = 12;
  logic mosi_drv = 1'b0;
  logic in_frame = 1'b0;

  // Strap level shows on the address pin outside frames
  assign mosi = in_frame ? mosi_drv : addr_strap;

  initial begin
    pin_a_drv = 1'b1;
    pin_b_drv = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_clk

  task automatic tw_start();
    wait_clk(H);
    pin_a_drv <= 1'b1;
    wait_clk(H);
    pin_b_drv <= 1'b1;
    wait_clk(H);
    pin_a_drv <= 1'b0;
    wait_clk(H);
    pin_b_drv <= 1'b0;
  endtask : tw_start

  task automatic tw_stop();
    wait_clk(H);
    pin_a_drv <= 1'b0;
    wait_clk(H);
    pin_b_drv <= 1'b1;
    wait_clk(H);
    pin_a_drv <= 1'b1;
  endtask : tw_stop

  // Data moves only while the clock is low, sampled mid high phase
  task automatic tw_bit(input logic b, output logic s);
    wait_clk(H / 2);
    pin_a_drv <= b;
    wait_clk(H / 2);
    pin_b_drv <= 1'b1;
    wait_clk(H / 2);
    #1 s = pin_a;
    wait_clk(H / 2);
    pin_b_drv <= 1'b0;
  endtask : tw_bit

  task automatic tw_byte(input logic [7:0] d, input logic ack_lvl,
                         output logic [7:0] q, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      tw_bit(d[i], s);
      q[i] = s;
    end
    tw_bit(ack_lvl, s);
    ack = !s;
  endtask : tw_byte

  // Select held low across the whole transfer
  task automatic spi_select(input logic lvl);
    #3.3;
    in_frame = !lvl;
    pin_b_drv = lvl;
  endtask : spi_select

  // Clock idles low, data set while low, read at the rising edge
  task automatic spi_byte(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      mosi_drv = d[i];
      #24 pin_a_drv = 1'b1;
      q[i] = miso;
      #24 pin_a_drv = 1'b0;
    end
  endtask : spi_byte
endmodule : hif_host_model

// ==== dv/test_host_interface_select.sv ====
// Self-checking bench for the host interface front end
`timescale 1ns/1ps
module test_host_interface_select;
  localparam int unsigned STARTUP = 200;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       report_event = 1'b0;
  logic       strap_sel = 1'b0;
  logic       strap_addr = 1'b0;
  logic       pin_a, pin_b, sel_pin, pin_a_drv, pin_b_drv, mosi;
  logic       data_out, data_oe, clock_out, clock_oe, sel_out, sel_oe;
  logic       irq_n, operational;
  logic [1:0] link_mode;
  logic [7:0] q, dat;
  logic [6:0] ad, rg;
  logic       ack;
  int         seed = 38;
  int         n_fail = 0;
  int         compares = 0;

  always #4 clk = ~clk;

  // Pull-ups on the shared pins; device drivers win while enabled
  assign pin_a   = pin_a_drv && (data_oe !== 1'b1 || data_out === 1'b1);
  assign pin_b   = (clock_oe === 1'b1) ? clock_out : pin_b_drv;
  assign sel_pin = (sel_oe === 1'b1) ? sel_out : strap_sel;

  hif_select #(.STARTUP_CYCLES(STARTUP), .BAUD_DIV(16)) i_dut (
    .clk(clk), .rst_n(rst_n), .spi_link_clk(pin_a), .slave_serial_data_in(pin_a),
    .slave_serial_data_out(data_out), .slave_serial_data_oe(data_oe),
    .slave_serial_clock_in(pin_b), .slave_serial_clock_out(clock_out),
    .slave_serial_clock_oe(clock_oe), .bus_address_strap(mosi),
    .interface_select_strap_n_in(sel_pin), .interface_select_strap_n_out(sel_out),
    .interface_select_strap_n_oe(sel_oe), .host_interrupt_n(irq_n),
    .report_event(report_event), .link_mode(link_mode), .operational(operational));

  hif_host_model i_host (
    .clk(clk), .pin_a(pin_a), .miso(sel_pin), .addr_strap(strap_addr),
    .pin_a_drv(pin_a_drv), .pin_b_drv(pin_b_drv), .mosi(mosi));

  function automatic logic [1:0] expect_mode(input logic sel, input logic adr);
    if ({sel, adr} == hif_pkg::LIN_STRAP_DEF) return 2'h2;
    return sel ? 2'h1 : 2'h0;
  endfunction : expect_mode

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic do_reset(input logic sel, input logic adr);
    @(posedge clk);
    strap_sel <= sel;
    strap_addr <= adr;
    rst_n <= 1'b0;
    tick(3);
    check("reset irq", 8'(irq_n), 8'h01);
    rst_n <= 1'b1;
  endtask : do_reset

  task automatic wait_op();
    for (int i = 0; i < STARTUP + 50 && operational !== 1'b1; i++) tick(1);
    tick(2);
    check("operational", 8'(operational), 8'h01);
  endtask : wait_op

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict

  initial begin
    for (int k = 0; k < 4; k++) begin
      do_reset(k[1], k[0]);
      tick(8);
      strap_sel <= ~k[1];
      strap_addr <= ~k[0];
      wait_op();
      check("link_mode", 8'(link_mode), 8'(expect_mode(k[1], k[0])));
      if (expect_mode(k[1], k[0]) == 2'h2) begin
        check("tx enable", 8'(clock_oe), 8'h01);
        check("tx idle", 8'(pin_b), 8'h01);
        check("transceiver enable", 8'(irq_n), 8'h01);
      end else begin
        check("hello irq", 8'(irq_n), 8'h00);
      end
      $display("test strap %0d done", k);
    end
    for (int a = 0; a < 2; a++) begin
      do_reset(1'b0, a[0]);
      wait_op();
      ad = a[0] ? hif_pkg::TWI_ADDR_HIGH : hif_pkg::TWI_ADDR_LOW;
      rg = 7'($random(seed));
      if (rg == 7'h00) rg = 7'h01;
      dat = 8'($random(seed));
      i_host.tw_start();
      i_host.tw_byte({ad ^ 7'h01, 1'b0}, 1'b1, q, ack);
      check("foreign address ack", 8'(ack), 8'h00);
      i_host.tw_stop();
      i_host.tw_start();
      i_host.tw_byte({ad, 1'b0}, 1'b1, q, ack);
      check("address ack", 8'(ack), 8'h01);
      i_host.tw_byte({1'b0, rg}, 1'b1, q, ack);
      i_host.tw_byte(dat, 1'b1, q, ack);
      check("data ack", 8'(ack), 8'h01);
      i_host.tw_stop();
      for (int r = 0; r < 2; r++) begin
        i_host.tw_start();
        i_host.tw_byte({ad, 1'b0}, 1'b1, q, ack);
        i_host.tw_byte(r == 0 ? {1'b1, rg} : 8'h80, 1'b1, q, ack);
        i_host.tw_start();
        i_host.tw_byte({ad, 1'b1}, 1'b1, q, ack);
        i_host.tw_byte(8'hff, 1'b1, q, ack);
        i_host.tw_stop();
        if (r == 0) check("read back", q, dat);
      end
      tick(4);
      check("irq after report read", 8'(irq_n), 8'h01);
      report_event <= 1'b1;
      tick(1);
      report_event <= 1'b0;
      tick(3);
      check("irq on event", 8'(irq_n), 8'h00);
      $display("test two-wire address %0d done", a);
    end
    // Run the link clock through reset and after it, select still high
    rst_n <= 1'b0;
    i_host.spi_byte(8'h00, q);
    do_reset(1'b1, 1'b0);
    i_host.spi_byte(8'h00, q);
    wait_op();
    i_host.spi_select(1'b0);
    tick(6);
    check("miso drive", 8'(sel_oe), 8'h01);
    i_host.spi_byte(8'h80, q);
    i_host.spi_byte(8'($random(seed)), q);
    i_host.spi_byte(8'($random(seed)), q);
    tick(4);
    check("irq after spi read", 8'(irq_n), 8'h01);
    i_host.spi_select(1'b1);
    tick(8);
    check("miso release", 8'(sel_oe), 8'h00);
    $display("test serial peripheral done");
    give_verdict();
  end

  initial begin
    #480000;
    n_fail++;
    $display("watchdog expired");
    give_verdict();
  end
endmodule : test_host_interface_select
